//--- bench/tb_uart_board_control_status_regs.sv
// self-checking bench for the board control and status register bank
module tb_uart_board_control_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import ubc_pkg::*;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
$display("FAIL %s exp %h got %h", n, e, g); end end
   int                     mismatches = 0;
   int                     n_compared = 0;
   logic                   clock_i = 1'b0;
   logic                   rstn_i = 1'b0;
   logic                   cmd_reset_i = 1'b0;
   logic                   reg_wr_i = 1'b0;
   logic                   reg_rd_i = 1'b0;
   logic [8:0]             reg_addr_i = 9'h000;
   logic [31:0]            reg_wdata_i = 32'h0;
   logic [31:0]            reg_rdata_o;
   logic [NSW-1:0]         switch_i = 8'ha5;
   logic [NDISC-1:0]       disc_req = '0;
   logic [NDISC-1:0]       disc_i;
   logic [NCH-1:0]         rx_req = '1;   // receive lines idle high
   logic [NCH-1:0]         rx_line_i;
   logic                   synth_clock_b_i;
   ubc_chan_ev_t [NCH-1:0] ev = '0;
   ubc_limits_t  [NCH-1:0] lim = {NCH{64'h0002_0000_ffff_0000}};   // high max 2, low wide
   logic [1:0]             far_irq_i = 2'b00;
   logic [NDISC-1:0]       term_en_o;
   logic                   synth_prog_run_o;
   logic                   synth_clear_o;
   logic                   host_irq_o;
   ubc_chan_out_t [NCH-1:0] chan_o;
   ubc_counts_t  [NCH-1:0] trig_lat_o;

   ubc_regs #(.REV_CODE(8'h3c)) ubc_regs_i (.clock_i(clock_i), .rstn_i(rstn_i),
      .cmd_reset_i(cmd_reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .switch_i(switch_i), .disc_i(disc_i), .synth_clock_b_i(synth_clock_b_i),
      .rx_line_i(rx_line_i), .chan_ev_i(ev), .limits_i(lim), .far_irq_i(far_irq_i),
      .term_en_o(term_en_o), .synth_prog_run_o(synth_prog_run_o),
      .synth_clear_o(synth_clear_o), .chan_o(chan_o), .trig_lat_o(trig_lat_o),
      .host_irq_o(host_irq_o));
   ubc_far_model ubc_far_model_i (.disc_req_i(disc_req), .rx_req_i(rx_req), .disc_o(disc_i),
      .rx_o(rx_line_i), .synth_clock_b_o(synth_clock_b_i));

   // 40 MHz bus clock
   initial
   begin
      forever #12.5 clock_i = ~clock_i;
   end

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // waits let pin synchronisers settle; results sampled off the edge
   task automatic tk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] v);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rc(input string n, input logic [8:0] a, input logic [31:0] e);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      tk(1);
      `CHK(n, e, reg_rdata_o)
   endtask
   // one-cycle event pulse on channel 0, mask in struct bit order
   task automatic pev(input logic [18:0] m);
      @(posedge clock_i);
      ev[0] <= ubc_chan_ev_t'(ev[0] | m);
      @(posedge clock_i);
      ev[0] <= ubc_chan_ev_t'(ev[0] & ~m);
   endtask

   task automatic t_reset;
      rc("base", OFF_BASE, 32'h0);
      rc("ctrl0", OFF_CH_CTRL, 32'h0);
      rc("ctrl5", 9'h100, 32'h0);
      rc("stat0", OFF_CH_STAT, 32'h0);
      rc("unmapped", 9'h008, 32'h0);
      rc("switch", OFF_SWITCH, 32'h0000_3ca5);
      $display("test reset done");
   endtask
   task automatic t_base;
      wr(OFF_BASE, 32'hffff_ffff);
      rc("base mask", OFF_BASE, 32'h0013_03ff);
      `CHK("term", 10'h3ff, term_en_o)
      `CHK("clear", 1'b1, synth_clear_o)
      `CHK("run held", 1'b0, synth_prog_run_o)
      wr(OFF_BASE, 32'h0001_0001);
      tk(3);
      `CHK("run", 1'b1, synth_prog_run_o)
      `CHK("term one", 10'h001, term_en_o)
      @(posedge clock_i);
      cmd_reset_i <= 1'b1;
      @(posedge clock_i);
      cmd_reset_i <= 1'b0;
      rc("cmd reset", OFF_BASE, 32'h0);
      `CHK("run off", 1'b0, synth_prog_run_o)
      $display("test base done");
   endtask
   task automatic t_flags;
      ev[0].wdma_idle <= 1'b1;
      pev(19'h5b400);   // transmit, parity, framing, both dma errors, read dma int
      rc("flags", OFF_CH_STAT, 32'h0000_01bd);
      wr(OFF_CH_STAT, 32'h0000_0005);
      rc("w1c", OFF_CH_STAT, 32'h0000_01b8);
      ev[0].wdma_idle <= 1'b0;
      wr(OFF_CH_STAT, 32'h0000_ffff);
      rc("cleared", OFF_CH_STAT, 32'h0);
      $display("test flags done");
   endtask
   task automatic t_irq;
      wr(OFF_CH_CTRL, 32'h0000_0030);
      rc("no global", OFF_CH_STAT, 32'h0800_0000);
      `CHK("irq gated", 1'b0, host_irq_o)
      far_irq_i <= 2'b01;
      wr(OFF_BASE, 32'h0010_0000);
      tk(3);
      `CHK("host irq", 1'b1, host_irq_o)
      rc("irq byte", OFF_SWITCH, 32'h4100_3ca5);
      rc("chan irq", OFF_CH_STAT, 32'h8800_0000);
      wr(OFF_CH_CTRL, 32'h0000_0020);
      far_irq_i <= 2'b00;
      tk(3);
      `CHK("force alone", 1'b0, chan_o[0].irq)
      wr(OFF_BASE, 32'h0);
      wr(OFF_CH_CTRL, 32'h0000_0040);
      pev(19'h00800);
      tk(3);
      `CHK("dma irq", 1'b1, chan_o[0].irq)
      `CHK("dma no global", 1'b0, host_irq_o)
      wr(OFF_CH_STAT, 32'h0000_0040);
      tk(3);
      `CHK("dma cleared", 1'b0, chan_o[0].irq)
      wr(OFF_CH_CTRL, 32'h0);
      $display("test irq done");
   endtask
   task automatic t_rxdone;
      ev[0].user_en <= 4'h2;
      pev(19'h20000);
      repeat (7) pev(19'h04000);
      rc("seven idle", OFF_CH_STAT, 32'h0);
      pev(19'h04000);
      rc("rx done", OFF_CH_STAT, 32'h0800_0002);
      ev[0].user_en <= 4'h0;
      wr(OFF_CH_STAT, 32'h0000_0002);
      $display("test rxdone done");
   endtask
   task automatic t_select;
      for (int s = 0; s < 10; s++)
      begin
         wr(OFF_CH_CTRL, 32'(s));
         disc_req = 10'h001 << s;
         tk(6);
         `CHK("trig high", 1'b1, chan_o[0].trig)
         disc_req = ~(10'h001 << s);
         tk(6);
         `CHK("trig low", 1'b0, chan_o[0].trig)
      end
      wr(OFF_CH_CTRL, 32'h0000_000a);
      disc_req = 10'h3ff;
      tk(6);
      `CHK("select ten", 1'b0, chan_o[0].trig)
      $display("test select done");
   endtask
   task automatic t_monitor;
      disc_req = '0;
      wr(OFF_CH_CTRL, 32'h0000_0100);
      tk(40);
      disc_req = 10'h001;
      tk(100);   // about twelve clock b periods high, well over the limit of two
      disc_req = '0;
      tk(40);
      rc("high over", OFF_CH_STAT, 32'h0000_1000);
      // latch while the low level is still counting, so the clear below is seen to act
      wr(OFF_CH_STAT, 32'h0002_0000);
      tk(3);
      `CHK("low latched", 1'b1, trig_lat_o[0].lo != 16'h0)
      wr(OFF_CH_STAT, 32'h0001_1000);
      wr(OFF_CH_STAT, 32'h0002_0000);
      tk(3);
      `CHK("counts zero", 32'h0, trig_lat_o[0])
      rc("mon clear", OFF_CH_STAT, 32'h0);
      wr(OFF_CH_CTRL, 32'h0);
      $display("test monitor done");
   endtask
   task automatic t_duplex;
      ev[0].tx_active <= 1'b1;
      tk(3);
      `CHK("half tx", 1'b1, chan_o[0].drive_en)
      `CHK("shared half", 1'b1, chan_o[0].shared_line)
      pev(19'h00040);
      tk(3);
      `CHK("rx dir", 1'b0, chan_o[0].drive_en)
      wr(OFF_CH_CTRL, 32'h0000_0200);
      tk(3);
      `CHK("full", 1'b1, chan_o[0].drive_en)
      `CHK("shared full", 1'b0, chan_o[0].shared_line)
      ev[0].tx_en <= 1'b1;
      ev[0].rx_en <= 1'b1;
      wr(OFF_CH_CTRL, 32'h0000_0400);
      tk(3);
      `CHK("auto tx", 1'b1, chan_o[0].drive_en)
      pev(19'h40000);
      tk(3);
      `CHK("auto rx", 1'b0, chan_o[0].drive_en)
      // a finished received message turns the line back to transmit
      pev(19'h20000);
      repeat (8) pev(19'h04000);
      tk(3);
      `CHK("auto back", 1'b1, chan_o[0].drive_en)
      ev[0] <= '0;
      wr(OFF_CH_STAT, 32'h0000_ffff);
      $display("test duplex done");
   endtask

   // main sequence
   initial
   begin
      repeat (16) @(posedge clock_i);
      rstn_i <= 1'b1;
      t_reset;
      t_base;
      t_flags;
      t_irq;
      t_rxdone;
      t_select;
      t_monitor;
      t_duplex;
      close_out;
   end
   // watchdog well past the few hundred cycles the tests need
   initial
   begin
      repeat (30000) @(posedge clock_i);
      mismatches++;
      close_out;
   end
endmodule

//--- bench/ubc_far_model.sv
// far-side model: front-panel discrete and receive lines plus synthesizer clock b
module ubc_far_model (
   input  wire logic [ubc_pkg::NDISC-1:0] disc_req_i,
   input  wire logic [ubc_pkg::NCH-1:0]   rx_req_i,
   output logic      [ubc_pkg::NDISC-1:0] disc_o,
   output logic      [ubc_pkg::NCH-1:0]   rx_o,
   output logic                           synth_clock_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import ubc_pkg::*;
   // clock b runs free, unrelated in phase and below a quarter of the bus clock
   initial
   begin
      synth_clock_b_o = 1'b0;
      forever #97 synth_clock_b_o = ~synth_clock_b_o;
   end
   // pins move a little after a request, never on a bus edge
   assign #3 disc_o = disc_req_i;
   assign #3 rx_o   = rx_req_i;
endmodule

//--- bench/ubc_regs_sva.sv
// assertion checker for the board control and status register bank, bound to its ports
module ubc_regs_sva #(
   parameter logic [7:0] REV_CODE = 8'h5a   // arbitrary value
) (
   input wire logic                       clock_i,
   input wire logic                       rstn_i,
   input wire logic                       cmd_reset_i,
   input wire logic [8:0]                 reg_addr_i,
   input wire logic                       reg_wr_i,
   input wire logic                       reg_rd_i,
   input wire logic [31:0]                reg_wdata_i,
   input wire logic [31:0]                reg_rdata_o,
   input wire ubc_pkg::ubc_chan_ev_t  [ubc_pkg::NCH-1:0] chan_ev_i,
   input wire logic [ubc_pkg::NDISC-1:0]  term_en_o,
   input wire logic                       synth_prog_run_o,
   input wire logic                       synth_clear_o,
   input wire ubc_pkg::ubc_chan_out_t [ubc_pkg::NCH-1:0] chan_o,
   input wire logic                       host_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import ubc_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic [31:0] base_wd_r;
   logic        irq_any;
   wire         base_wr = reg_wr_i && reg_addr_i == OFF_BASE;
   wire         quiet   = !base_wr && !cmd_reset_i;
   // last word written to base control; the reset command wins, as in the register
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         base_wd_r <= 32'h0000_0000;
      else if (cmd_reset_i)
         base_wd_r <= 32'h0000_0000;
      else if (base_wr)
         base_wd_r <= reg_wdata_i;
   end
   // any channel asking for the host
   always_comb
   begin
      irq_any = 1'b0;
      foreach (chan_o[i]) irq_any = irq_any | chan_o[i].irq;
   end
   // spare base bits land outside the compared slices, so a masked store still passes
   term_en_a: assert property (base_wr && !cmd_reset_i ##1 quiet [*3] |->
      term_en_o == base_wd_r[9:0]) else $error("termination enables differ from base");
   synth_out_a: assert property (base_wr && !cmd_reset_i ##1 quiet [*3] |->
      synth_clear_o == base_wd_r[17] && synth_prog_run_o == (base_wd_r[16] && !base_wd_r[17]))
      else $error("synthesizer controls differ from base");
   cmd_clear_a: assert property (cmd_reset_i && !base_wr ##1 quiet [*2] |-> ##1
      term_en_o == '0 && !synth_clear_o && !synth_prog_run_o) else $error("base kept after reset");
   // read data stands from the edge after the read strobe is taken
   rev_port_a: assert property (reg_rd_i && reg_addr_i == OFF_SWITCH |-> ##1
      reg_rdata_o[15:8] == REV_CODE && reg_rdata_o[23:16] == 8'h00) else $error("revision byte wrong");
   unmapped_rd_a: assert property (reg_rd_i && reg_addr_i == 9'h008 |-> ##1
      reg_rdata_o == 32'h0) else $error("unmapped read not zero");
   stat_spare_a: assert property (reg_rd_i && reg_addr_i == OFF_CH_STAT |-> ##1
      (reg_rdata_o & 32'h77ff_0c00) == 32'h0) else $error("status spare or command bits read set");
   ctrl_spare_a: assert property (reg_rd_i && reg_addr_i == OFF_CH_CTRL |-> ##1
      reg_rdata_o[31:11] == 21'h0) else $error("control spare bits read set");
   // channel and host lines are registered together; the gate is the enable one edge back
   host_irq_a: assert property (irq_any && $past(base_wd_r[BC_MINT]) |-> host_irq_o)
      else $error("host interrupt missing");
   global_off_a: assert property (!$past(base_wd_r[BC_MINT]) |-> !host_irq_o)
      else $error("host interrupt without global enable");
   drive_a: assert property (chan_o[0].drive_en |-> $past(chan_ev_i[0].tx_active))
      else $error("driver on without transmit");
   cover property ($rose(chan_o[0].irq));
   cover property (chan_o[0].irq && !host_irq_o);
   cover property ($fell(chan_o[0].drive_en));
   cover property (base_wr ##3 term_en_o != '0);
endmodule

bind ubc_regs ubc_regs_sva #(.REV_CODE(REV_CODE)) ubc_regs_sva_i (.clock_i(clock_i),
   .rstn_i(rstn_i), .cmd_reset_i(cmd_reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .chan_ev_i(chan_ev_i), .term_en_o(term_en_o), .synth_prog_run_o(synth_prog_run_o),
   .synth_clear_o(synth_clear_o), .chan_o(chan_o), .host_irq_o(host_irq_o));

//--- hdl/ubc_pkg.sv
// shared constants and carrier types for the board control and status register bank
package ubc_pkg;
   localparam int NCH   = 6;     // channels with full control/status here
   localparam int NIRQ  = 8;     // interrupt lines shown in the switch port
   localparam int NDISC = 10;    // discrete trigger inputs
   localparam int NSW   = 8;     // user switch positions
   localparam int CW    = 16;    // trigger duration counter width

   // byte offsets on the register port
   localparam logic [8:0] OFF_BASE    = 9'h000;
   localparam logic [8:0] OFF_SWITCH  = 9'h004;
   localparam logic [8:0] OFF_CH_CTRL = 9'h010;
   localparam logic [8:0] OFF_CH_STAT = 9'h014;
   localparam logic [8:0] CH_STRIDE   = 9'h030;

   // base control fields
   localparam int BC_TERM_LSB = 0;
   localparam int BC_PROG_EN  = 16;
   localparam int BC_CLEAR    = 17;
   localparam int BC_MINT     = 20;
   localparam logic [31:0] BASE_MASK = 32'h0013_03ff;
   localparam logic [31:0] BASE_RST  = 32'h0000_0000;

   // switch port fields
   localparam int SW_REV_LSB = 8;
   localparam int SW_IRQ_LSB = 24;

   // channel control fields
   localparam int CC_SEL_LSB = 0;
   localparam int CC_SEL_W   = 4;
   localparam int CC_INT_EN  = 4;
   localparam int CC_FORCE   = 5;
   localparam int CC_WDMA_IE = 6;
   localparam int CC_RDMA_IE = 7;
   localparam int CC_TMON    = 8;
   localparam int CC_FDX     = 9;
   localparam int CC_AUTO    = 10;
   localparam int CC_W       = 11;
   localparam logic [CC_W-1:0] CTRL_RST = 11'h000;

   // channel status fields
   localparam int ST_TX_DONE  = 0;
   localparam int ST_RX_DONE  = 1;
   localparam int ST_PARITY   = 2;
   localparam int ST_FRAMING  = 3;
   localparam int ST_WDMA_ERR = 4;
   localparam int ST_RDMA_ERR = 5;
   localparam int ST_WDMA_INT = 6;
   localparam int ST_RDMA_INT = 7;
   localparam int ST_WDMA_IDL = 8;
   localparam int ST_RDMA_IDL = 9;
   localparam int ST_HI_OVER  = 12;
   localparam int ST_HI_UNDER = 13;
   localparam int ST_LO_OVER  = 14;
   localparam int ST_LO_UNDER = 15;
   localparam int ST_CLR_CNT  = 16;
   localparam int ST_LAT_CNT  = 17;
   localparam int ST_USER     = 27;
   localparam int ST_CHIRQ    = 31;
   localparam logic [15:0] LATCH_MASK = 16'hf0ff;

   // receive message ends after this many idle bit periods
   localparam logic [3:0] IDLE_BITS = 4'h8;

   typedef struct packed {
      logic       tx_done;
      logic       rx_byte;
      logic       parity_err;
      logic       framing_err;
      logic       bit_tick;
      logic       wdma_err;
      logic       rdma_err;
      logic       wdma_int;
      logic       rdma_int;
      logic       wdma_idle;
      logic       rdma_idle;
      logic       tx_active;
      logic       dir_cmd;
      logic       tx_en;
      logic       rx_en;
      logic [3:0] user_en;
   } ubc_chan_ev_t;

   typedef struct packed {
      logic [CW-1:0] hi_max;
      logic [CW-1:0] hi_min;
      logic [CW-1:0] lo_max;
      logic [CW-1:0] lo_min;
   } ubc_limits_t;

   typedef struct packed {
      logic [CW-1:0] hi;
      logic [CW-1:0] lo;
   } ubc_counts_t;

   typedef struct packed {
      logic trig;
      logic drive_en;
      logic shared_line;
      logic irq;
   } ubc_chan_out_t;
endpackage

//--- hdl/ubc_regs.sv
// common and per-channel control/status register bank of the serial board
module ubc_regs #(
   parameter logic [7:0] REV_CODE = 8'h5a   // arbitrary value
) (
   input  wire logic                          clock_i,
   input  wire logic                          rstn_i,
   input  wire logic                          cmd_reset_i,
   input  wire logic [8:0]                    reg_addr_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   input  wire logic [31:0]                   reg_wdata_i,
   output logic      [31:0]                   reg_rdata_o,
   input  wire logic [ubc_pkg::NSW-1:0]       switch_i,
   input  wire logic [ubc_pkg::NDISC-1:0]     disc_i,
   input  wire logic                          synth_clock_b_i,
   input  wire logic [ubc_pkg::NCH-1:0]       rx_line_i,
   input  wire ubc_pkg::ubc_chan_ev_t [ubc_pkg::NCH-1:0] chan_ev_i,
   input  wire ubc_pkg::ubc_limits_t  [ubc_pkg::NCH-1:0] limits_i,
   input  wire logic [ubc_pkg::NIRQ-ubc_pkg::NCH-1:0]    far_irq_i,
   output logic      [ubc_pkg::NDISC-1:0]     term_en_o,
   output logic                               synth_prog_run_o,
   output logic                               synth_clear_o,
   output ubc_pkg::ubc_chan_out_t [ubc_pkg::NCH-1:0]     chan_o,
   output ubc_pkg::ubc_counts_t   [ubc_pkg::NCH-1:0]     trig_lat_o,
   output logic                               host_irq_o
);
   import ubc_pkg::*;

   typedef struct packed {
      logic [31:0]                   base;
      logic [NCH-1:0][CC_W-1:0]      ctrl;
      logic [NCH-1:0][15:0]          flags;
      logic [NCH-1:0]                have_byte;
      logic [NCH-1:0][3:0]           idle_cnt;
      logic [NCH-1:0]                dir_rx;
      logic [NCH-1:0][CW-1:0]        hi_cnt;
      logic [NCH-1:0][CW-1:0]        lo_cnt;
      logic [NCH-1:0]                stopped;
      logic [NCH-1:0]                trig_prev;
      ubc_counts_t [NCH-1:0]         lat;
      ubc_chan_out_t [NCH-1:0]       out;
      logic [NDISC-1:0]              disc_s1;
      logic [NDISC-1:0]              disc_s2;
      logic [NCH-1:0]                rxl_s1;
      logic [NCH-1:0]                rxl_s2;
      logic [NSW-1:0]                sw_s1;
      logic [NSW-1:0]                sw_s2;
      logic                          ckb_s1;
      logic                          ckb_s2;
      logic                          ckb_prev;
      logic [31:0]                   rdata;
      logic                          prog_run;
      logic                          synth_clr;
      logic [NDISC-1:0]              term;
      logic                          host_irq;
   } ubc_state_t;

   localparam ubc_state_t STATE_RST = '0;

   ubc_state_t st_r;
   ubc_state_t st_nxt;

   // all behaviour in one pass over the state; per-channel work is one loop
   always_comb
   begin
      logic [NIRQ-1:0] irq_vec;
      logic [15:0]     set_v;
      logic [15:0]     clr_v;
      logic [31:0]     rd_v;
      logic            ckb_tick;
      logic            trig_v;
      logic            user_v;
      logic            msg_done;
      logic [CC_W-1:0] cc;
      irq_vec  = '0;
      set_v    = '0;
      clr_v    = '0;
      rd_v     = '0;
      trig_v   = 1'b0;
      user_v   = 1'b0;
      msg_done = 1'b0;
      cc       = '0;
      ckb_tick = 1'b0;
      st_nxt   = st_r;

      // every pin but far_irq_i crosses two flops before any logic looks at it
      st_nxt.disc_s1  = disc_i;
      st_nxt.disc_s2  = st_r.disc_s1;
      st_nxt.rxl_s1   = rx_line_i;
      st_nxt.rxl_s2   = st_r.rxl_s1;
      st_nxt.sw_s1    = switch_i;
      st_nxt.sw_s2    = st_r.sw_s1;
      st_nxt.ckb_s1   = synth_clock_b_i;
      st_nxt.ckb_s2   = st_r.ckb_s1;
      st_nxt.ckb_prev = st_r.ckb_s2;
      // clock b is far slower than the system clock, so its rising edge is a tick
      ckb_tick = st_r.ckb_s2 & ~st_r.ckb_prev;

      // base control: only defined bits are stored, so spare bits read zero
      if (reg_wr_i && reg_addr_i == OFF_BASE)
         st_nxt.base = reg_wdata_i & BASE_MASK;
      if (cmd_reset_i)
         st_nxt.base = BASE_RST;

      for (int ch = 0; ch < NCH; ch++)
      begin
         cc = st_r.ctrl[ch];
         set_v = '0;
         clr_v = '0;
         msg_done = 1'b0;

         // channel control write
         if (reg_wr_i && reg_addr_i == 9'(OFF_CH_CTRL + 9'(ch) * CH_STRIDE))
            st_nxt.ctrl[ch] = reg_wdata_i[CC_W-1:0];

         // status write clears the ones written, never stores
         if (reg_wr_i && reg_addr_i == 9'(OFF_CH_STAT + 9'(ch) * CH_STRIDE))
            clr_v = reg_wdata_i[15:0] & LATCH_MASK;

         // receive message end: a byte, then eight idle bit periods
         if (chan_ev_i[ch].rx_byte)
         begin
            st_nxt.have_byte[ch] = 1'b1;
            st_nxt.idle_cnt[ch]  = '0;
         end
         else if (!st_r.rxl_s2[ch])
            st_nxt.idle_cnt[ch] = '0;
         else if (chan_ev_i[ch].bit_tick && st_r.have_byte[ch])
         begin
            if (st_r.idle_cnt[ch] == IDLE_BITS - 4'h1)
            begin
               msg_done = 1'b1;
               st_nxt.have_byte[ch] = 1'b0;
               st_nxt.idle_cnt[ch]  = '0;
            end
            else
               st_nxt.idle_cnt[ch] = st_r.idle_cnt[ch] + 4'h1;
         end

         // event sources for the latched flags
         set_v[ST_TX_DONE]  = chan_ev_i[ch].tx_done;
         set_v[ST_RX_DONE]  = msg_done;
         set_v[ST_PARITY]   = chan_ev_i[ch].parity_err;
         set_v[ST_FRAMING]  = chan_ev_i[ch].framing_err;
         set_v[ST_WDMA_ERR] = chan_ev_i[ch].wdma_err;
         set_v[ST_RDMA_ERR] = chan_ev_i[ch].rdma_err;
         set_v[ST_WDMA_INT] = chan_ev_i[ch].wdma_int;
         set_v[ST_RDMA_INT] = chan_ev_i[ch].rdma_int;

         // selected trigger input; an out-of-range select reads low
         trig_v = 1'b0;
         for (int d = 0; d < NDISC; d++)
            if (cc[CC_SEL_LSB +: CC_SEL_W] == CC_SEL_W'(d))
               trig_v = st_r.disc_s2[d];
         st_nxt.out[ch].trig = trig_v;

         // trigger monitor, advanced once per clock b tick
         if (ckb_tick)
         begin
            st_nxt.trig_prev[ch] = trig_v;
            if (cc[CC_TMON])
            begin
               if (trig_v != st_r.trig_prev[ch])
               begin
                  st_nxt.stopped[ch] = 1'b0;
                  // a level cut short by a clear is not judged
                  if (!st_r.stopped[ch] && !trig_v)
                  begin
                     set_v[ST_HI_OVER]  = st_r.hi_cnt[ch] > limits_i[ch].hi_max;
                     set_v[ST_HI_UNDER] = st_r.hi_cnt[ch] < limits_i[ch].hi_min;
                     st_nxt.hi_cnt[ch] = '0;
                  end
                  else if (!st_r.stopped[ch])
                  begin
                     set_v[ST_LO_OVER]  = st_r.lo_cnt[ch] > limits_i[ch].lo_max;
                     set_v[ST_LO_UNDER] = st_r.lo_cnt[ch] < limits_i[ch].lo_min;
                     st_nxt.lo_cnt[ch] = '0;
                  end
               end
               else if (!st_r.stopped[ch])
               begin
                  // saturate so a stuck level cannot wrap to a short count
                  if (trig_v && st_r.hi_cnt[ch] != {CW{1'b1}})
                     st_nxt.hi_cnt[ch] = st_r.hi_cnt[ch] + 1'b1;
                  if (!trig_v && st_r.lo_cnt[ch] != {CW{1'b1}})
                     st_nxt.lo_cnt[ch] = st_r.lo_cnt[ch] + 1'b1;
               end
            end
         end

         // write-only counter commands in the status word
         if (reg_wr_i && reg_addr_i == 9'(OFF_CH_STAT + 9'(ch) * CH_STRIDE))
         begin
            if (reg_wdata_i[ST_LAT_CNT])
            begin
               st_nxt.lat[ch].hi = st_r.hi_cnt[ch];
               st_nxt.lat[ch].lo = st_r.lo_cnt[ch];
            end
            if (reg_wdata_i[ST_CLR_CNT])
            begin
               st_nxt.hi_cnt[ch]  = '0;
               st_nxt.lo_cnt[ch]  = '0;
               st_nxt.stopped[ch] = 1'b1;
            end
         end

         // set after clear so a same-cycle event is never lost
         st_nxt.flags[ch] = (st_r.flags[ch] & ~clr_v) | (set_v & LATCH_MASK);
         st_nxt.flags[ch][ST_WDMA_IDL] = chan_ev_i[ch].wdma_idle;
         st_nxt.flags[ch][ST_RDMA_IDL] = chan_ev_i[ch].rdma_idle;

         // interrupt combining from the registered flags
         user_v = (|(st_r.flags[ch][ST_FRAMING:ST_TX_DONE] & chan_ev_i[ch].user_en))
                  | cc[CC_FORCE];
         irq_vec[ch] = (user_v & cc[CC_INT_EN] & st_r.base[BC_MINT])
                     | (cc[CC_WDMA_IE] & st_r.flags[ch][ST_WDMA_INT])
                     | (cc[CC_RDMA_IE] & st_r.flags[ch][ST_RDMA_INT]);
         st_nxt.out[ch].irq = irq_vec[ch];

         // line direction; the direction flag only matters in half duplex
         if (cc[CC_FDX])
            st_nxt.dir_rx[ch] = 1'b0;
         else if (cc[CC_AUTO] && chan_ev_i[ch].tx_en && chan_ev_i[ch].rx_en)
         begin
            if (chan_ev_i[ch].tx_done)
               st_nxt.dir_rx[ch] = 1'b1;
            else if (msg_done)
               st_nxt.dir_rx[ch] = 1'b0;
         end
         else if (chan_ev_i[ch].dir_cmd)
            st_nxt.dir_rx[ch] = ~st_r.dir_rx[ch];
         st_nxt.out[ch].shared_line = ~cc[CC_FDX];
         st_nxt.out[ch].drive_en = chan_ev_i[ch].tx_active
                                 & (cc[CC_FDX] | ~st_r.dir_rx[ch]);

         // read mux for this channel
         if (reg_addr_i == 9'(OFF_CH_CTRL + 9'(ch) * CH_STRIDE))
            rd_v = 32'(st_r.ctrl[ch]);
         if (reg_addr_i == 9'(OFF_CH_STAT + 9'(ch) * CH_STRIDE))
         begin
            rd_v = 32'(st_r.flags[ch]);
            rd_v[ST_USER]  = user_v;
            rd_v[ST_CHIRQ] = st_r.out[ch].irq;
         end
      end

      // the two channels beyond this bank report their lines in from outside
      for (int k = NCH; k < NIRQ; k++)
         irq_vec[k] = far_irq_i[k-NCH];

      // common reads; any other address reads zero
      if (reg_addr_i == OFF_BASE)
         rd_v = st_r.base;
      if (reg_addr_i == OFF_SWITCH)
      begin
         rd_v = '0;
         rd_v[NSW-1:0] = st_r.sw_s2;
         rd_v[SW_REV_LSB +: 8] = REV_CODE;
         for (int k = 0; k < NIRQ; k++)
            rd_v[SW_IRQ_LSB + k] = (k < NCH) ? st_r.out[k % NCH].irq : far_irq_i[k % 2];
      end
      if (reg_rd_i)
         st_nxt.rdata = rd_v;

      // base control outputs; clear overrides programming
      st_nxt.term      = st_r.base[BC_TERM_LSB +: NDISC];
      st_nxt.prog_run  = st_r.base[BC_PROG_EN] & ~st_r.base[BC_CLEAR];
      st_nxt.synth_clr = st_r.base[BC_CLEAR];
      // the global enable gates every channel, dma included, before the host sees it
      st_nxt.host_irq  = st_r.base[BC_MINT] & (|irq_vec);
   end

   // single state register
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_r <= STATE_RST;
      else
         st_r <= st_nxt;
   end

   // outputs straight from the state flops
   assign reg_rdata_o      = st_r.rdata;
   assign term_en_o        = st_r.term;
   assign synth_prog_run_o = st_r.prog_run;
   assign synth_clear_o    = st_r.synth_clr;
   assign chan_o           = st_r.out;
   assign trig_lat_o       = st_r.lat;
   assign host_irq_o       = st_r.host_irq;
endmodule
